// ===== verilog/sgcb_global_ctrl.sv
`timescale 1ns/1ps
module sgcb_global_ctrl
   import sgcb_pkg::*;
#(
   parameter longint NORM_AGE_CYC = SGCB_NORM_AGE_CYC,
   parameter int FAST_AGE_CYC = SGCB_FAST_AGE_CYC
)(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic pause_strap_pin_i,
   input wire logic backoff_strap_pin_i,
   input wire logic [SGCB_NPORT-1:0] link_up_i,
   input wire logic an_tx_pause_i,
   input wire logic an_rx_pause_i,
   input wire logic frm_valid_i,
   input wire logic [15:0] frm_type_len_i,
   input wire logic [47:0] frm_da_i,
   input wire logic frm_is_fc_i,
   input wire logic frm_error_i,
   input wire logic [11:0] frm_len_i,
   input wire logic [15:0] frm_payload_len_i,
   output logic frm_drop_o,
   output logic frm_forward_o,
   output logic tx_pause_en_o,
   output logic rx_pause_en_o,
   output logic aggr_backoff_o,
   output logic age_tick_o,
   output logic age_flush_o,
   output logic [SGCB_NPORT-1:0] link_up_o
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [SGCB_NPORT-1:0] link_s1;
   logic [SGCB_NPORT-1:0] link_s2;
   logic [SGCB_NPORT-1:0] link_d;
   logic [1:0] strap_s1;
   logic [1:0] strap_s2;
   logic strap_done;
   logic [1:0] strap_age;

   always_ff @(posedge mclk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         link_s1 <= '0;
         link_s2 <= '0;
         link_d <= '0;
         strap_s1 <= 2'h0;
         strap_s2 <= 2'h0;
         strap_age <= 2'h0;
      end
      else
      begin
         link_s1 <= link_up_i;
         link_s2 <= link_s1;
         link_d <= link_s2;
         strap_s1 <= {pause_strap_pin_i, backoff_strap_pin_i};
         strap_s2 <= strap_s1;
         // Counts two edges so both synchroniser stages hold the straps
         strap_age <= {strap_age[0], 1'b1};
      end

   assign link_up_o = link_s2;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [1:0] ctrl0;
   logic [7:0] ctrl1;

   // Address match, shared by the write strobes and the read mux
   function automatic logic addr_hit(input logic [7:0] addr,
      input logic [7:0] target);
      return addr == target;
   endfunction

   wire sel0 = addr_hit(reg_addr_i, SGCB_CTRL0_ADDR);
   wire sel1 = addr_hit(reg_addr_i, SGCB_CTRL1_ADDR);
   wire wr0 = reg_wr_i && sel0;
   wire wr1 = reg_wr_i && sel1;
   wire strap_load = strap_age[1] && !strap_done;

   // Straps are loaded at the third edge after release, once both
   // synchroniser stages hold them; a write to global control one
   // on that same edge loses to the strap load.
   always_ff @(posedge mclk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         ctrl0 <= SGCB_CTRL0_RST[1:0];
         ctrl1 <= SGCB_CTRL1_RST;
         strap_done <= 1'b0;
      end
      else
      begin
         strap_done <= strap_done | strap_age[1];
         if (strap_load)
         begin
            ctrl1[SGCB_C1_TXPD_BIT] <= strap_s2[1];
            ctrl1[SGCB_C1_RXPD_BIT] <= strap_s2[1];
            ctrl1[SGCB_C1_BACKOFF_BIT] <= strap_s2[0];
         end
         else if (wr1)
            ctrl1 <= reg_wdata_i;
         if (wr0)
            ctrl0 <= reg_wdata_i[1:0];
      end

   wire conf_mode = ctrl0[SGCB_C0_CONF_BIT];
   wire link_age = ctrl0[SGCB_C0_LINKAGE_BIT];
   wire pass_all = ctrl1[SGCB_C1_PASSALL_BIT];
   wire big2k = ctrl1[SGCB_C1_BIG2K_BIT];
   wire len_chk = ctrl1[SGCB_C1_LENCHK_BIT];
   wire age_en = ctrl1[SGCB_C1_AGEEN_BIT];
   wire fast_age = ctrl1[SGCB_C1_FASTAGE_BIT];

   // Unmapped addresses read zero
   wire [7:0] rd0 = {6'h00, ctrl0};
   assign reg_rdata_o = sel0 ? rd0 :
                        sel1 ? ctrl1 : 8'h00;

   // ==========================================================
   // Flow control and back-off
   // ==========================================================
   assign tx_pause_en_o = an_tx_pause_i & ~ctrl1[SGCB_C1_TXPD_BIT];
   assign rx_pause_en_o = an_rx_pause_i & ~ctrl1[SGCB_C1_RXPD_BIT];
   assign aggr_backoff_o = ctrl1[SGCB_C1_BACKOFF_BIT];

   // ==========================================================
   // Frame filter
   // ==========================================================
   wire fc_hit = conf_mode ?
      (frm_type_len_i == SGCB_PAUSE_TYPE || frm_da_i == SGCB_PAUSE_DA) :
      frm_is_fc_i;
   wire len_bad = len_chk && (frm_type_len_i < SGCB_LEN_LIMIT) &&
                  (frm_type_len_i != frm_payload_len_i);
   wire size_bad = frm_len_i > (big2k ? SGCB_MAX_2K : SGCB_MAX_STD);
   wire err_drop = !pass_all && (frm_error_i || size_bad);
   wire drop_now = fc_hit || len_bad || err_drop;

   always_ff @(posedge mclk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         frm_drop_o <= 1'b0;
         frm_forward_o <= 1'b0;
      end
      else
      begin
         frm_drop_o <= frm_valid_i & drop_now;
         frm_forward_o <= frm_valid_i & ~drop_now;
      end

   // ==========================================================
   // Aging timer
   // ==========================================================
   // Normal period counter is 34 bits so 300 s fits at 40 MHz.
   logic [33:0] age_cnt;
   sgcb_age_t age_state;
   sgcb_age_t next_age_state;
   wire link_loss = |(link_d & ~link_s2);
   wire loss_age = link_age && link_loss;
   wire fast_pass = (age_state == SGCB_AGE_FAST);
   wire use_fast = fast_age | fast_pass;
   wire [33:0] period = use_fast ? 34'(FAST_AGE_CYC - 1) :
                        34'(NORM_AGE_CYC - 1);
   wire age_done = age_en && (age_cnt >= period);

   // A link drop during a fast pass restarts it: the drop wins over the
   // end of the pass so that no loss goes without its fast pass.
   always_comb
   begin
      next_age_state = age_state;
      case (age_state)
         SGCB_AGE_IDLE:
            if (loss_age)
               next_age_state = SGCB_AGE_FAST;
            else if (age_en)
               next_age_state = SGCB_AGE_NORM;
         SGCB_AGE_NORM:
            if (loss_age)
               next_age_state = SGCB_AGE_FAST;
            else if (!age_en)
               next_age_state = SGCB_AGE_IDLE;
         SGCB_AGE_FAST:
            if (!loss_age && age_done)
               next_age_state = SGCB_AGE_NORM;
         default:
            next_age_state = SGCB_AGE_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         age_cnt <= 34'h0;
         age_state <= SGCB_AGE_IDLE;
         age_tick_o <= 1'b0;
         age_flush_o <= 1'b0;
      end
      else
      begin
         age_state <= next_age_state;
         age_tick_o <= age_done;
         age_flush_o <= link_loss;
         if (loss_age || !age_en || age_done)
            age_cnt <= 34'h0;
         else
            age_cnt <= age_cnt + 34'h1;
      end
endmodule

// ===== verilog/sgcb_pkg.sv
package sgcb_pkg;
   // Register offsets on the management register port
   localparam logic [7:0] SGCB_CTRL0_ADDR = 8'h02;
   localparam logic [7:0] SGCB_CTRL1_ADDR = 8'h03;
   // Control 0 low bits
   localparam int SGCB_C0_CONF_BIT = 1;
   localparam int SGCB_C0_LINKAGE_BIT = 0;
   // Global control one bits
   localparam int SGCB_C1_PASSALL_BIT = 7;
   localparam int SGCB_C1_BIG2K_BIT = 6;
   localparam int SGCB_C1_TXPD_BIT = 5;
   localparam int SGCB_C1_RXPD_BIT = 4;
   localparam int SGCB_C1_LENCHK_BIT = 3;
   localparam int SGCB_C1_AGEEN_BIT = 2;
   localparam int SGCB_C1_FASTAGE_BIT = 1;
   localparam int SGCB_C1_BACKOFF_BIT = 0;
   // Reset values, strap bits overlaid at release
   localparam logic [7:0] SGCB_CTRL0_RST = 8'h00;
   localparam logic [7:0] SGCB_CTRL1_RST = 8'h04;
   // Frame constants
   localparam logic [15:0] SGCB_PAUSE_TYPE = 16'h8808;
   localparam logic [47:0] SGCB_PAUSE_DA = 48'h0180C2000001;
   localparam logic [15:0] SGCB_LEN_LIMIT = 16'h05DC;
   localparam logic [11:0] SGCB_MAX_STD = 12'h5EE;
   localparam logic [11:0] SGCB_MAX_2K = 12'h800;
   // Aging timing at 40 MHz
   localparam int SGCB_CLK_MHZ = 40;
   localparam int SGCB_FAST_AGE_US = 800;
   localparam int SGCB_NORM_AGE_S = 300;
   localparam int SGCB_FAST_AGE_CYC = SGCB_FAST_AGE_US * SGCB_CLK_MHZ;
   localparam longint SGCB_NORM_AGE_CYC =
      longint'(SGCB_NORM_AGE_S) * 1000000 * SGCB_CLK_MHZ;
   localparam int SGCB_NPORT = 4;
   typedef enum logic [1:0] {
      SGCB_AGE_IDLE = 2'b00,
      SGCB_AGE_NORM = 2'b01,
      SGCB_AGE_FAST = 2'b10
   } sgcb_age_t;
endpackage

// ===== verification/sgcb_checker.sv
`timescale 1ns/1ps
// ====================
// Port checker for the global control bank
module sgcb_checker
   import sgcb_pkg::*;
(
   input wire logic mclk_i, nrst_i, frm_valid_i, frm_is_fc_i, frm_error_i,
   input wire logic an_tx_pause_i, an_rx_pause_i, frm_drop_o, frm_forward_o,
   input wire logic tx_pause_en_o, rx_pause_en_o, age_tick_o, age_flush_o,
   input wire logic [7:0] reg_addr_i, reg_rdata_o,
   input wire logic [15:0] frm_type_len_i,
   input wire logic [SGCB_NPORT-1:0] link_up_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   wire a2 = reg_addr_i == SGCB_CTRL0_ADDR;
   wire a3 = reg_addr_i == SGCB_CTRL1_ADDR;
   property p_tx;
      a3 |-> tx_pause_en_o == (an_tx_pause_i & ~reg_rdata_o[5]);
   endproperty
   a_tx: assert property (p_tx) else $error("tx pause wrong");
   property p_rx;
      a3 |-> rx_pause_en_o == (an_rx_pause_i & ~reg_rdata_o[4]);
   endproperty
   a_rx: assert property (p_rx) else $error("rx pause wrong");
   property p_conf;
      frm_valid_i && a2 && reg_rdata_o[1] &&
         frm_type_len_i == SGCB_PAUSE_TYPE |=> frm_drop_o;
   endproperty
   a_conf: assert property (p_conf) else $error("type kept");
   property p_fc;
      frm_valid_i && a2 && !reg_rdata_o[1] && frm_is_fc_i |=> frm_drop_o;
   endproperty
   a_fc: assert property (p_fc) else $error("fc frame kept");
   property p_err;
      frm_valid_i && a3 && !reg_rdata_o[7] && frm_error_i |=> frm_drop_o;
   endproperty
   a_err: assert property (p_err) else $error("bad frame kept");
   property p_one;
      frm_drop_o || frm_forward_o |-> $past(frm_valid_i) &&
         (frm_drop_o ^ frm_forward_o);
   endproperty
   a_one: assert property (p_one) else $error("verdict wrong");
   property p_flush;
      |($past(link_up_o) & ~link_up_o) |-> ##[0:2] age_flush_o;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush");
   property p_noage;
      (a3 && !reg_rdata_o[2]) [*2] |-> !age_tick_o;
   endproperty
   a_noage: assert property (p_noage) else $error("aged while off");
endmodule
bind sgcb_global_ctrl sgcb_checker u_chk (.mclk_i, .nrst_i, .frm_valid_i,
   .frm_is_fc_i, .frm_error_i, .an_tx_pause_i, .an_rx_pause_i, .frm_drop_o,
   .frm_forward_o, .tx_pause_en_o, .rx_pause_en_o, .age_tick_o, .age_flush_o,
   .reg_addr_i, .reg_rdata_o, .frm_type_len_i, .link_up_o);

// ===== verification/testbench.sv
`timescale 1ns/1ps
// ====================
// Random and corner stimulus for the control bank
module testbench;
   import sgcb_pkg::*;
   logic mclk_i = 0, nrst_i = 0, wr = 0, ps = 1, bs = 1, atx = 0, arx = 0;
   logic fv = 0, fc = 0, fe = 0, drop, fwd, txp, rxp, abo, tick, flush;
   logic [7:0] ra = 0, wd = 0, rd, c0 = 0, c1 = 0;
   logic [3:0] lu = 4'hF, lo;
   logic [15:0] tl = 0, pl = 0;
   logic [47:0] da = 0;
   logic [11:0] fl = 0;
   int num_errors = 0, checks_done = 0, n;
   // Short aging periods keep the run brief
   sgcb_global_ctrl #(.NORM_AGE_CYC(200), .FAST_AGE_CYC(20)) dut (.mclk_i,
      .nrst_i, .reg_addr_i(ra), .reg_wr_i(wr), .reg_wdata_i(wd),
      .reg_rdata_o(rd), .pause_strap_pin_i(ps), .backoff_strap_pin_i(bs),
      .link_up_i(lu), .an_tx_pause_i(atx), .an_rx_pause_i(arx),
      .frm_valid_i(fv), .frm_type_len_i(tl), .frm_da_i(da), .frm_is_fc_i(fc),
      .frm_error_i(fe), .frm_len_i(fl), .frm_payload_len_i(pl),
      .frm_drop_o(drop), .frm_forward_o(fwd), .tx_pause_en_o(txp),
      .rx_pause_en_o(rxp), .aggr_backoff_o(abo), .age_tick_o(tick),
      .age_flush_o(flush), .link_up_o(lo));
   initial forever #12.5 mclk_i = ~mclk_i;
   task print_verdict();
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, e, input string nm);
      checks_done++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task step(int k = 1);
      repeat (k) @(posedge mclk_i);
      #2;
   endtask
   task wreg(input logic [7:0] a, d);
      ra = a;
      wd = d;
      wr = 1;
      step();
      wr = 0;
      step();
   endtask
   // Counts cycles up to the next aging pass
   task wait_tick();
      n = 0;
      do
      begin
         step();
         n++;
      end
      while (tick !== 1'b1 && n < 999);
      if (n == 999)
      begin
         num_errors++;
         print_verdict();
      end
   endtask
   function automatic logic edrop();
      logic fh = c0[1] ? (tl == SGCB_PAUSE_TYPE || da == SGCB_PAUSE_DA) : fc;
      logic lb = c1[3] && tl < SGCB_LEN_LIMIT && tl != pl;
      return fh | lb | (!c1[7] && (fe || fl > (c1[6] ? SGCB_MAX_2K :
         SGCB_MAX_STD)));
   endfunction
   initial
   begin
      n = $urandom(32'h47F5);
      step(12);
      nrst_i = 1;
      ra = 8'h03;
      step(4);
      chk(rd, 8'h35, "strap reset");
      chk(lo, 4'hF, "link sync");
      nrst_i = 0;
      ps = 0;
      bs = 0;
      step(3);
      chk(rd, 8'h04, "held in reset");
      nrst_i = 1;
      step(4);
      chk(rd, 8'h04, "plain reset");
      for (int i = 0; i < 400; i++)
      begin
         c0 = 8'($urandom);
         c1 = 8'($urandom);
         wreg(8'h02, c0);
         wreg(8'h03, c1);
         c0 &= 8'h03;
         ra = {7'h01, 1'($urandom)};
         {atx, arx, fc, fe} = 4'($urandom);
         tl = $urandom_range(0, 2) ? 16'($urandom_range(0, 1600)) : 16'h8808;
         da = $urandom_range(0, 2) ? {16'($urandom), 32'($urandom)} :
            SGCB_PAUSE_DA;
         pl = $urandom_range(0, 1) ? tl : 16'($urandom_range(0, 1600));
         fl = 12'($urandom_range(1500, 2070));
         fv = 1;
         step();
         fv = 0;
         chk(drop, edrop(), "drop");
         chk(fwd, !edrop(), "forward");
         chk(txp, atx & ~c1[5], "tx pause");
         chk(rxp, arx & ~c1[4], "rx pause");
         chk(abo, c1[0], "backoff");
         chk(rd, ra[0] ? c1 : c0, "readback");
      end
      wreg(8'h03, 8'h06);
      wait_tick();
      wait_tick();
      chk(n, 20, "fast period");
      wreg(8'h02, 8'h01);
      wreg(8'h03, 8'h04);
      wait_tick();
      wait_tick();
      chk(n, 200, "normal period");
      step(9);
      lu = 4'hB;
      step(2);
      chk(lo, 4'hB, "link sync");
      step();
      chk(flush, 1, "flush");
      wait_tick();
      chk(n, 20, "link loss pass");
      wait_tick();
      chk(n, 200, "back to normal");
      wreg(8'h03, 8'h00);
      n = 0;
      repeat (250)
      begin
         step();
         n += tick;
      end
      chk(n, 0, "aging off");
      print_verdict();
   end
endmodule
